// File: rtl/ppp_pkg.sv
`default_nettype none
// Shared constants for the parallel programming port and its programmer.
package ppp_pkg;
	// Action codes presented on the two action bits at each strobe pulse.
	localparam logic [1:0] PPP_ACT_ADDR = 2'h0;
	localparam logic [1:0] PPP_ACT_DATA = 2'h1;
	localparam logic [1:0] PPP_ACT_CMD  = 2'h2;
	localparam logic [1:0] PPP_ACT_NONE = 2'h3;
	// Command byte bit positions.
	localparam int PPP_CMD_BIT_FLASH_WR = 4;
	localparam int PPP_CMD_BIT_FLASH_RD = 1;
	localparam int PPP_CMD_BIT_SIG_RD   = 3;
	// Command byte values.
	localparam logic [7:0] PPP_CMD_FLASH_RD = 8'h02;
	localparam logic [7:0] PPP_CMD_SIG_RD   = 8'h08;
	localparam logic [7:0] PPP_CMD_FLASH_WR = 8'h10;
	localparam logic [7:0] PPP_CMD_RESET    = 8'h00;
	// Flash geometry.
	localparam int PPP_ADDR_BITS  = 9;
	localparam int PPP_FLASH_WORDS = 512;
	localparam int PPP_SIG_BYTES  = 3;
	localparam logic [7:0] PPP_ADDR_HI_MAX = 8'h01;
	localparam logic [7:0] PPP_SIG_ADDR_MAX = 8'h02;
	// Clock rate and busy time after the write strobe falls.
	localparam int PPP_CLK_HZ       = 50000000;
	localparam int PPP_BUSY_MIN_US  = 500;
	localparam int PPP_BUSY_MAX_US  = 900;
	localparam int PPP_BUSY_US      = 700;
	localparam int PPP_BUSY_CYCLES  = (PPP_CLK_HZ / 1000000) * PPP_BUSY_US;
	// Programmer strobe width in system cycles, and reset values.
	localparam int PPP_STROBE_CYCLES = 4;
	localparam logic [7:0] PPP_BYTE_RESET = 8'h00;
endpackage
`default_nettype wire

// File: rtl/ppp_if.sv
`default_nettype none
// Pins between the programmer and the device; data bus resolved from enables.
interface ppp_if;
	logic       load_strobe_pin;    // Positive pulse performs a load.
	logic       strobe_action_bit0; // Action code bit 0.
	logic       strobe_action_bit1; // Action code bit 1.
	logic       byte_half_select;   // Low selects low byte.
	logic       wr_n;               // Write pulse, active low.
	logic       oe_n;               // Output enable, active low.
	logic       prog_done_flag;     // High when ready.
	logic [7:0] data_dev;           // Device drive value.
	logic       data_dev_oe;        // Device drives the bus.
	logic [7:0] data_prg;           // Programmer drive value.
	logic       data_prg_oe;        // Programmer drives the bus.
	logic [7:0] data_bus;           // Resolved bus level.
	// The device wins only when it drives; otherwise the programmer value, else the pull-ups.
	assign data_bus = data_dev_oe ? data_dev : (data_prg_oe ? data_prg : 8'hff);
	modport dev (input load_strobe_pin, strobe_action_bit0, strobe_action_bit1, byte_half_select,
		wr_n, oe_n, data_bus, output prog_done_flag, data_dev, data_dev_oe);
	modport prg (output load_strobe_pin, strobe_action_bit0, strobe_action_bit1, byte_half_select,
		wr_n, oe_n, data_prg, data_prg_oe, input prog_done_flag, data_bus);
endinterface
`default_nettype wire

// File: rtl/ppp_device.sv
// How it works
// (R1) Ready flag low while busy, high otherwise.
// (R2) Drive data only while output enable low.
// (R3) Byte select low low byte, high high.
// (R4) Strobe pulse performs load chosen by action.
// (R5) Write/enable act on last loaded command.
// (R6) Programmer loads read command, high, low address.
// (R7) Word address is nine bits wide.
// (R8) Flash read gives byte chosen by select.
// (R9) Signature read loads command then low address.
// (R10) Signature read drives chosen identification byte.
// (R11) Busy stays low fixed time after write.
// (R12) Chip erase write pulse five to fifteen ms. Not implemented: there is no chip erase command.
// (R13) Fuse write pulse one to 1.8 ms. Not implemented: there is no fuse write command.
// (R14) Action codes: address, data, command, none.
`default_nettype none
module ppp_device
	import ppp_pkg::*;
#(
	parameter int BUSY_CYCLES = PPP_BUSY_CYCLES,
	parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary identification value.
	parameter logic [7:0] SIG_BYTE1 = 8'h3C, // Arbitrary identification value.
	parameter logic [7:0] SIG_BYTE2 = 8'h11  // Arbitrary identification value.
)(
	input  wire logic clk_sys_in,  // System clock.
	input  wire logic reset_in,    // Synchronous reset, active high.
	input  wire logic enable_in,   // Clock enable; state frozen while low.
	ppp_if.dev        pins         // Programming pins.
);
	// Two-stage synchronisers for all pin inputs (6 controls + 8 data).
	logic [13:0] sync_a;          // First stage, read only by sync_b.
	logic [13:0] sync_b;          // Second stage, read by logic.
	logic        strobe_prev;     // Previous synchronised strobe.
	logic        wr_prev;         // Previous synchronised write.
	// Loaded state.
	logic [7:0]  cmd;             // Last command byte.
	logic [7:0]  addr_hi;         // Address high byte.
	logic [7:0]  addr_lo;         // Address low byte.
	logic [7:0]  data_lo;         // Data byte for low half.
	logic [7:0]  data_hi;         // Data byte for high half.
	logic        busy;            // Operation in progress.
	logic        ready;           // Registered ready flag, always the inverse of busy.
	logic [31:0] busy_cnt;        // Cycles left of busy.
	logic [7:0]  dout;            // Registered data output.
	logic        dout_oe;         // Registered data enable.
	logic [7:0]  next_cmd;
	logic [7:0]  next_addr_hi;
	logic [7:0]  next_addr_lo;
	logic [7:0]  next_data_lo;
	logic [7:0]  next_data_hi;
	logic        next_busy;
	logic [31:0] next_busy_cnt;
	logic [7:0]  next_dout;
	logic        next_dout_oe;
	// The flash array itself.
	logic [15:0] flash_mem [0:PPP_FLASH_WORDS-1];
	// Synchronised view of the pins.
	logic        s_strobe;
	logic        s_act0;
	logic        s_act1;
	logic        s_bsel;
	logic        s_wr_n;
	logic        s_oe_n;
	logic [7:0]  s_data;
	logic [PPP_ADDR_BITS-1:0] word_addr;
	logic        strobe_rise;
	logic        wr_fall;
	logic [15:0] rd_word;

	assign s_strobe = sync_b[0];
	assign s_act0   = sync_b[1];
	assign s_act1   = sync_b[2];
	assign s_bsel   = sync_b[3];
	assign s_wr_n   = sync_b[4];
	assign s_oe_n   = sync_b[5];
	assign s_data   = sync_b[13:6];
	// Nine-bit word address from the low bit of the high byte and the low byte.
	assign word_addr   = {addr_hi[0], addr_lo}; // R7
	assign strobe_rise = s_strobe && !strobe_prev;
	assign wr_fall     = !s_wr_n && wr_prev;
	assign rd_word     = flash_mem[word_addr];

	// Next-state logic for loads, busy timing and data output.
	always_comb
	begin
		next_cmd      = cmd;
		next_addr_hi  = addr_hi;
		next_addr_lo  = addr_lo;
		next_data_lo  = data_lo;
		next_data_hi  = data_hi;
		next_busy     = busy;
		next_busy_cnt = busy_cnt;
		next_dout     = dout;
		next_dout_oe  = 1'b0;
		// A rising strobe performs the load selected by the action bits.
		if (strobe_rise)
		begin
			case ({s_act1, s_act0}) // R4 R14
				PPP_ACT_ADDR:
				begin
					// Byte select picks which address byte is loaded.
					if (s_bsel) // R3
						next_addr_hi = s_data;
					else
						next_addr_lo = s_data;
				end
				PPP_ACT_DATA:
				begin
					if (s_bsel) // R3
						next_data_hi = s_data;
					else
						next_data_lo = s_data;
				end
				PPP_ACT_CMD:  next_cmd = s_data; // R5
				default:      next_cmd = cmd;
			endcase
		end
		// A falling write starts the busy period of fixed length.
		if (wr_fall && !busy)
		begin
			next_busy     = 1'b1; // R1
			next_busy_cnt = BUSY_CYCLES - 1; // R11
		end
		else if (busy)
		begin
			// Count down; ready returns when the count ends.
			if (busy_cnt == 32'h0000_0000)
				next_busy = 1'b0; // R11
			else
				next_busy_cnt = busy_cnt - 32'h0000_0001;
		end
		// Output enable low drives the byte chosen by the current command.
		if (!s_oe_n)
		begin
			next_dout_oe = 1'b1; // R2
			if (cmd[PPP_CMD_BIT_SIG_RD])
			begin
				// Identification byte chosen by the low address.
				case (addr_lo) // R10
					8'h00:   next_dout = SIG_BYTE0;
					8'h01:   next_dout = SIG_BYTE1;
					8'h02:   next_dout = SIG_BYTE2;
					default: next_dout = 8'h00;
				endcase
			end
			else if (cmd[PPP_CMD_BIT_FLASH_RD])
				next_dout = s_bsel ? rd_word[15:8] : rd_word[7:0]; // R8 R3
			else
				next_dout = 8'h00;
		end
	end

	// Register all state; the clock enable freezes everything.
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			sync_a      <= 14'h0030;
			sync_b      <= 14'h0030;
			strobe_prev <= 1'b0;
			wr_prev     <= 1'b1;
			cmd         <= PPP_CMD_RESET;
			addr_hi     <= PPP_BYTE_RESET;
			addr_lo     <= PPP_BYTE_RESET;
			data_lo     <= PPP_BYTE_RESET;
			data_hi     <= PPP_BYTE_RESET;
			busy        <= 1'b0;
			ready       <= 1'b1;
			busy_cnt    <= 32'h0000_0000;
			dout        <= PPP_BYTE_RESET;
			dout_oe     <= 1'b0;
		end
		else if (enable_in)
		begin
			sync_a      <= {pins.data_bus, pins.oe_n, pins.wr_n, pins.byte_half_select,
				pins.strobe_action_bit1, pins.strobe_action_bit0, pins.load_strobe_pin};
			sync_b      <= sync_a;
			strobe_prev <= s_strobe;
			wr_prev     <= s_wr_n;
			cmd         <= next_cmd;
			addr_hi     <= next_addr_hi;
			addr_lo     <= next_addr_lo;
			data_lo     <= next_data_lo;
			data_hi     <= next_data_hi;
			busy        <= next_busy;
			ready       <= !next_busy;
			busy_cnt    <= next_busy_cnt;
			dout        <= next_dout;
			dout_oe     <= next_dout_oe;
		end
	end

	// Flash word write on the falling write edge under a write command.
	always_ff @(posedge clk_sys_in)
	begin
		if (enable_in && !reset_in && wr_fall && !busy && cmd[PPP_CMD_BIT_FLASH_WR])
			flash_mem[word_addr] <= {data_hi, data_lo}; // R5
	end

	// Outputs come straight from flip-flops.
	assign pins.prog_done_flag = ready; // R1
	assign pins.data_dev       = dout;
	assign pins.data_dev_oe    = dout_oe; // R2
endmodule
`default_nettype wire

// File: rtl/ppp_programmer.sv
`default_nettype none
// Programmer end: runs flash-read, signature-read and flash-write sequences.
module ppp_programmer
	import ppp_pkg::*;
(
	input  wire logic        clk_sys_in,   // System clock.
	input  wire logic        reset_in,     // Synchronous reset, active high.
	input  wire logic        enable_in,    // Clock enable.
	input  wire logic        start_in,     // One-cycle request.
	input  wire logic [1:0]  op_in,        // 0 flash read, 1 signature read, 2 flash write.
	input  wire logic [8:0]  addr_in,      // Word or signature address.
	input  wire logic [15:0] wdata_in,     // Word to write.
	output logic             busy_out,     // Sequence running.
	output logic             done_out,     // One-cycle completion pulse.
	output logic [15:0]      rdata_out,    // Read result.
	ppp_if.prg               pins          // Programming pins.
);
	typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_NEXT, ST_OE_LO, ST_OE_HI, ST_WR, ST_WAIT, ST_END} ppp_state_t;
	ppp_state_t state;
	ppp_state_t next_state;
	logic [2:0]  step;        // Load step index.
	logic [2:0]  next_step;
	logic [3:0]  cnt;         // Phase cycle counter.
	logic [3:0]  next_cnt;
	logic [1:0]  op;
	logic [1:0]  next_op;
	logic [8:0]  addr;
	logic [8:0]  next_addr;
	logic [15:0] wdata;
	logic [15:0] next_wdata;
	logic [15:0] rdata;
	logic [15:0] next_rdata;
	logic        rdy_a;       // First synchroniser stage of ready.
	logic        rdy_s;       // Second stage.
	logic [7:0]  bus_a;
	logic [7:0]  bus_s;
	// Registered pin drives.
	logic strobe, next_strobe, a0, next_a0, a1, next_a1, bsel, next_bsel;
	logic wrn, next_wrn, oen, next_oen, doe, next_doe, done, next_done;
	logic [7:0] dval, next_dval;
	logic [2:0] nsteps;

	// Number of loads: read/write cmd+hi+lo (+2 data for write), signature cmd+lo.
	always_comb
	begin
		case (op)
			2'h1:    nsteps = 3'h2; // R9
			2'h2:    nsteps = 3'h5;
			default: nsteps = 3'h3; // R6
		endcase
	end

	// Sequencer next state.
	always_comb
	begin
		next_state = state; next_step = step; next_cnt = cnt; next_op = op;
		next_addr = addr; next_wdata = wdata; next_rdata = rdata;
		next_strobe = strobe; next_a0 = a0; next_a1 = a1; next_bsel = bsel;
		next_wrn = wrn; next_oen = oen; next_doe = doe; next_dval = dval; next_done = 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (start_in)
				begin
					next_op = op_in; next_addr = addr_in; next_wdata = wdata_in;
					next_step = 3'h0; next_state = ST_SETUP; next_cnt = 4'h0;
				end
			end
			ST_SETUP:
			begin
				// Place action code, select and byte for this load.
				next_doe = 1'b1;
				if (step == 3'h0)
				begin
					{next_a1, next_a0} = PPP_ACT_CMD; next_bsel = 1'b0;
					next_dval = (op == 2'h0) ? PPP_CMD_FLASH_RD :
						(op == 2'h1) ? PPP_CMD_SIG_RD : PPP_CMD_FLASH_WR;
				end
				else if (step == 3'h1 && op != 2'h1)
				begin
					{next_a1, next_a0} = PPP_ACT_ADDR; next_bsel = 1'b1;
					next_dval = {7'h00, addr[8]}; // R7
				end
				else if (step <= 3'h2)
				begin
					{next_a1, next_a0} = PPP_ACT_ADDR; next_bsel = 1'b0;
					next_dval = addr[7:0];
				end
				else
				begin
					{next_a1, next_a0} = PPP_ACT_DATA; next_bsel = (step == 3'h4);
					next_dval = (step == 3'h4) ? wdata[15:8] : wdata[7:0]; // R3
				end
				next_cnt = cnt + 4'h1;
				if (cnt == 4'(PPP_STROBE_CYCLES)) begin next_state = ST_PULSE; next_cnt = 4'h0; end
			end
			ST_PULSE:
			begin
				next_strobe = 1'b1; // R4
				next_cnt = cnt + 4'h1;
				if (cnt == 4'(PPP_STROBE_CYCLES)) begin next_state = ST_NEXT; next_cnt = 4'h0; next_strobe = 1'b0; end
			end
			ST_NEXT:
			begin
				next_cnt = cnt + 4'h1;
				if (cnt == 4'(PPP_STROBE_CYCLES))
				begin
					next_cnt = 4'h0;
					next_step = (op == 2'h1 && step == 3'h0) ? 3'h2 : step + 3'h1;
					if (step + 3'h1 >= nsteps || (op == 2'h1 && step == 3'h2))
					begin
						next_doe = 1'b0; next_bsel = 1'b0;
						next_state = (op == 2'h2) ? ST_WR : ST_OE_LO;
					end
					else
						next_state = ST_SETUP;
				end
			end
			ST_OE_LO:
			begin
				// Low byte first, then high byte for flash.
				next_oen = 1'b0; next_cnt = cnt + 4'h1;
				if (cnt == 4'hA) next_rdata[7:0] = bus_s; // R8
				// The select flips early: the high byte needs six cycles of round trip before capture.
				if (cnt == 4'h8 && op == 2'h0) next_bsel = 1'b1;
				if (cnt == 4'hF) begin next_rdata[15:8] = (op == 2'h0) ? bus_s : 8'h00; next_state = ST_OE_HI; end
			end
			ST_OE_HI: begin next_oen = 1'b1; next_bsel = 1'b0; next_state = ST_END; end
			ST_WR:
			begin
				next_wrn = 1'b0; next_cnt = cnt + 4'h1;
				if (cnt == 4'(PPP_STROBE_CYCLES)) begin next_wrn = 1'b1; next_cnt = 4'h0; next_state = ST_WAIT; end
			end
			ST_WAIT:
			begin
				// Wait fifteen cycles for ready to drop, then until it returns high.
				next_cnt = (cnt == 4'hF) ? cnt : cnt + 4'h1;
				if (cnt == 4'hF && rdy_s) next_state = ST_END;
			end
			ST_END: begin next_done = 1'b1; next_state = ST_IDLE; end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			state <= ST_IDLE; step <= 3'h0; cnt <= 4'h0; op <= 2'h0; addr <= 9'h000;
			wdata <= 16'h0000; rdata <= 16'h0000; rdy_a <= 1'b1; rdy_s <= 1'b1;
			bus_a <= 8'h00; bus_s <= 8'h00; strobe <= 1'b0; a0 <= 1'b1; a1 <= 1'b1;
			bsel <= 1'b0; wrn <= 1'b1; oen <= 1'b1; doe <= 1'b0; dval <= 8'h00; done <= 1'b0;
		end
		else if (enable_in)
		begin
			state <= next_state; step <= next_step; cnt <= next_cnt; op <= next_op; addr <= next_addr;
			wdata <= next_wdata; rdata <= next_rdata; rdy_a <= pins.prog_done_flag; rdy_s <= rdy_a;
			bus_a <= pins.data_bus; bus_s <= bus_a; strobe <= next_strobe; a0 <= next_a0; a1 <= next_a1;
			bsel <= next_bsel; wrn <= next_wrn; oen <= next_oen; doe <= next_doe; dval <= next_dval;
			done <= next_done;
		end
	end

	assign pins.load_strobe_pin    = strobe;
	assign pins.strobe_action_bit0 = a0;
	assign pins.strobe_action_bit1 = a1;
	assign pins.byte_half_select   = bsel;
	assign pins.wr_n               = wrn;
	assign pins.oe_n               = oen;
	assign pins.data_prg           = dval;
	assign pins.data_prg_oe        = doe;
	assign busy_out  = (state != ST_IDLE);
	assign done_out  = done;
	assign rdata_out = rdata;
endmodule
`default_nettype wire

// File: verif/ppp_checker.sv
`default_nettype none
// Watches the pins between the two ends of the programming port.
module ppp_checker
#(
	parameter int BUSY_CYCLES = 20 // Busy span of the device.
)(
	input wire logic       clk_sys_in,         // System clock.
	input wire logic       reset_in,           // Synchronous reset.
	input wire logic       load_strobe_pin,    // Load pulse.
	input wire logic       strobe_action_bit0, // Action code bit 0.
	input wire logic       strobe_action_bit1, // Action code bit 1.
	input wire logic       wr_n,               // Write pulse.
	input wire logic       oe_n,               // Output enable.
	input wire logic       prog_done_flag,     // Ready flag.
	input wire logic       data_dev_oe,        // Device drives the bus.
	input wire logic       data_prg_oe,        // Programmer drives the bus.
	input wire logic [7:0] data_bus            // Resolved bus.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] lo_cnt;      // Cycles the ready flag has stayed low.
	logic [15:0] next_lo_cnt; // Next value of that count.

	// Counts busy cycles so that the span can be bounded.
	always_comb
	begin
		next_lo_cnt = lo_cnt;
		if (reset_in || prog_done_flag)
			next_lo_cnt = '0;
		else if (lo_cnt != 16'hffff)
			next_lo_cnt = lo_cnt + 16'h0001;
	end

	// Registers the busy count.
	always_ff @(posedge clk_sys_in)
	begin
		lo_cnt <= next_lo_cnt;
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);

	a_ready_after_reset: assert property ($fell(reset_in) |-> prog_done_flag && !data_dev_oe)
		else $error("ready flag or bus drive wrong after reset");
	a_drive_needs_oe: assert property (data_dev_oe |-> !$past(oe_n, 3))
		else $error("device drives bus without output enable");
	a_oe_answer: assert property ((!oe_n)[*4] |-> data_dev_oe)
		else $error("device not driving after output enable");
	a_busy_start: assert property ($fell(wr_n) && prog_done_flag |-> ##4 !prog_done_flag)
		else $error("write pulse did not start busy");
	a_busy_span: assert property ($rose(prog_done_flag) |-> lo_cnt >= BUSY_CYCLES - 1 && lo_cnt <= BUSY_CYCLES + 1)
		else $error("busy span wrong length");
	a_busy_bounded: assert property (lo_cnt <= BUSY_CYCLES + 1)
		else $error("busy lasts too long");
	a_strobe_width: assert property ($rose(load_strobe_pin) |-> load_strobe_pin[*4])
		else $error("load pulse too short");
	a_action_steady: assert property (load_strobe_pin && $past(load_strobe_pin) |->
		$stable({strobe_action_bit1, strobe_action_bit0, data_bus}))
		else $error("action or data moved during load pulse");
	a_write_width: assert property ($fell(wr_n) |-> (!wr_n)[*4])
		else $error("write pulse too short");
	a_no_contention: assert property (!(data_dev_oe && data_prg_oe))
		else $error("both ends drive the bus");
endmodule
`default_nettype wire

// File: verif/ppp_tb_top.sv
`default_nettype none
`define CHK(what, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("[FAIL] %s expected %h seen %h", what, exp, got); \
		end \
	end
// Drives the programmer's user side and judges that user side and the pins.
module ppp_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ppp_pkg::*;
	localparam int BUSY = 20; // Short busy span for simulation.
	localparam logic [7:0] SIGS [4] = '{8'ha7, 8'h4e, 8'hc3, 8'h00}; // Arbitrary identification values.
	localparam logic [8:0] WA [3] = '{9'h000, 9'h1ff, 9'h0a5}; // Word addresses.
	localparam logic [15:0] WD [3] = '{16'h1234, 16'hbeef, 16'h00ff}; // Words written.
	logic        clk_sys_in; // Clock.
	logic        reset_in;   // Reset.
	logic        start;      // Request pulse.
	logic [1:0]  op;         // Operation.
	logic [8:0]  addr;       // Address.
	logic [15:0] wdata;      // Write word.
	logic        busy;       // Programmer busy.
	logic        done;       // Completion pulse.
	logic [15:0] rdata;      // Read word.
	logic        mon_lo;     // Low byte on the bus is checked.
	logic        mon_hi;     // High byte on the bus is checked.
	logic [15:0] exp_word;   // Word expected on the bus.
	logic [1:0]  pin_q;      // Last output enable and byte select.
	logic        strobe_q;   // Last load pulse level.
	logic [10:0] ld_q [$];   // Loads seen on the pins.
	int          age;        // Cycles the enable and select held.
	int          wn;         // Wait bound.
	int          bad_count;  // Mismatches.
	int          cmp_count;  // Comparisons.

	ppp_if ppp_if_i();
	ppp_device #(.BUSY_CYCLES(BUSY), .SIG_BYTE0(SIGS[0]), .SIG_BYTE1(SIGS[1]), .SIG_BYTE2(SIGS[2])) ppp_device_i (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .enable_in(1'b1), .pins(ppp_if_i));
	ppp_programmer ppp_programmer_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .enable_in(1'b1),
		.start_in(start), .op_in(op), .addr_in(addr), .wdata_in(wdata), .busy_out(busy), .done_out(done),
		.rdata_out(rdata), .pins(ppp_if_i));
	ppp_checker #(.BUSY_CYCLES(BUSY)) ppp_checker_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.load_strobe_pin(ppp_if_i.load_strobe_pin), .strobe_action_bit0(ppp_if_i.strobe_action_bit0),
		.strobe_action_bit1(ppp_if_i.strobe_action_bit1), .wr_n(ppp_if_i.wr_n), .oe_n(ppp_if_i.oe_n),
		.prog_done_flag(ppp_if_i.prog_done_flag), .data_dev_oe(ppp_if_i.data_dev_oe),
		.data_prg_oe(ppp_if_i.data_prg_oe), .data_bus(ppp_if_i.data_bus));

	// Toggles the clock every half period.
	always #10 clk_sys_in = ~clk_sys_in;

	// Judges the bus once enable and select have settled, and logs each load.
	always @(negedge clk_sys_in)
	begin
		if ({ppp_if_i.oe_n, ppp_if_i.byte_half_select} !== pin_q)
			age = 0;
		else if (age < 8)
			age++;
		pin_q = {ppp_if_i.oe_n, ppp_if_i.byte_half_select};
		if (age >= 4 && !reset_in)
		begin
			`CHK("bus drive", !ppp_if_i.oe_n, ppp_if_i.data_dev_oe)
			if (!ppp_if_i.oe_n && (ppp_if_i.byte_half_select ? mon_hi : mon_lo))
				`CHK("bus byte", ppp_if_i.byte_half_select ? exp_word[15:8] : exp_word[7:0], ppp_if_i.data_bus)
		end
		if (ppp_if_i.load_strobe_pin && !strobe_q)
			ld_q.push_back({ppp_if_i.byte_half_select, ppp_if_i.strobe_action_bit1,
				ppp_if_i.strobe_action_bit0, ppp_if_i.data_bus});
		strobe_q = ppp_if_i.load_strobe_pin;
	end

	// Runs one operation and checks its loads, a read's answer and a write's busy span.
	task automatic run_op(input logic [1:0] o, input logic [8:0] a, input logic [15:0] w, input logic [15:0] rd);
		logic [10:0] exp_q [$];
		int n;
		int lo;
		exp_q = {{1'b0, PPP_ACT_CMD, (o == 2'd0) ? PPP_CMD_FLASH_RD : (o == 2'd1) ? PPP_CMD_SIG_RD : PPP_CMD_FLASH_WR}};
		if (o != 2'd1)
			exp_q.push_back({1'b1, PPP_ACT_ADDR, 7'h00, a[8]});
		exp_q.push_back({1'b0, PPP_ACT_ADDR, a[7:0]});
		if (o == 2'd2)
		begin
			exp_q.push_back({1'b0, PPP_ACT_DATA, w[7:0]});
			exp_q.push_back({1'b0, PPP_ACT_DATA, w[15:8]});
		end
		mon_lo = (o != 2'd2);
		mon_hi = (o == 2'd0);
		exp_word = rd;
		ld_q.delete();
		@(posedge clk_sys_in);
		start <= 1'b1;
		op <= o;
		addr <= a;
		wdata <= w;
		@(posedge clk_sys_in);
		start <= 1'b0;
		@(negedge clk_sys_in);
		`CHK("busy_out", 1'b1, busy)
		n = 0;
		lo = 0;
		while (done !== 1'b1 && n < 3000)
		begin
			@(negedge clk_sys_in);
			n++;
			if (ppp_if_i.prog_done_flag === 1'b0)
				lo++;
		end
		`CHK("done_out", 1'b1, done)
		if (o != 2'd2)
			`CHK("rdata_out", rd, rdata)
		else
			`CHK("busy span", 1'b1, lo >= BUSY - 1 && lo <= BUSY + 1)
		`CHK("load count", exp_q.size(), ld_q.size())
		for (int i = 0; i < exp_q.size(); i++)
			`CHK("load", exp_q[i], ld_q[i] & ((exp_q[i][9:8] == PPP_ACT_ADDR) ? 11'h7ff : 11'h3ff))
		mon_lo = 1'b0;
		mon_hi = 1'b0;
	endtask

	// Prints the verdict and ends the run.
	task automatic close_out();
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Cuts a hang short.
	initial
	begin
		repeat (40000) @(posedge clk_sys_in);
		bad_count++;
		close_out();
	end

	// Main sequence.
	initial
	begin
		{clk_sys_in, reset_in, start, op, addr, wdata} = {1'b0, 1'b1, 28'h0};
		{mon_lo, mon_hi, exp_word, pin_q, strobe_q} = '0;
		{age, wn, bad_count, cmp_count} = '0;
		repeat (5) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(negedge clk_sys_in);
		`CHK("ready after reset", 1'b1, ppp_if_i.prog_done_flag)
		// Words at both address ends and between, written then read back.
		for (int i = 0; i < 3; i++)
			run_op(2'd2, WA[i], WD[i], 16'h0000);
		for (int i = 0; i < 3; i++)
			run_op(2'd0, WA[i], 16'h0000, WD[i]);
		// Every identification byte, then one past the last reads zero.
		for (int i = 0; i < 4; i++)
			run_op(2'd1, 9'(i), 16'h0000, {8'h00, SIGS[i]});
		// Reset lands while the device is busy.
		@(posedge clk_sys_in);
		start <= 1'b1;
		op <= 2'd2;
		addr <= 9'h003;
		@(posedge clk_sys_in);
		start <= 1'b0;
		while (ppp_if_i.prog_done_flag !== 1'b0 && wn < 1000)
		begin
			@(negedge clk_sys_in);
			wn++;
		end
		`CHK("busy before mid reset", 1'b0, ppp_if_i.prog_done_flag)
		@(posedge clk_sys_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(negedge clk_sys_in);
		`CHK("ready after mid reset", 1'b1, ppp_if_i.prog_done_flag)
		`CHK("busy after mid reset", 1'b0, busy)
		run_op(2'd1, 9'h002, 16'h0000, {8'h00, SIGS[2]});
		close_out();
	end
endmodule
`default_nettype wire
